// file: dram_addr_mux_timing_cfg.sv
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`default_nettype none
module dram_addr_mux_timing_cfg #(
   parameter int ADDR_W = 24
) (
   input  wire logic                    hclk,       // system clock, 50 MHz
   input  wire logic                    hresetn,    // asynchronous reset, active low
   input  wire logic                    hsel,       // slave select
   input  wire logic [31:0]             haddr,      // byte address
   input  wire logic [1:0]              htrans,     // transfer type
   input  wire logic                    hwrite,     // write when high
   input  wire logic [2:0]              hsize,      // word transfers only
   input  wire logic [31:0]             hwdata,     // write data
   input  wire logic                    hready,     // bus ready
   output logic                         hreadyout,  // always ready
   output logic                         hresp,      // always OKAY
   output logic      [31:0]             hrdata,     // read data
   input  wire dram_cfg_pkg::dram_req_s req,        // access request
   output logic                         req_ack,    // column cycle of the request
   output dram_cfg_pkg::dram_pins_s     pins        // dram address and strobes
);
   dram_cfg_pkg::ctl_state_s s;
   dram_cfg_pkg::ctl_state_s next_s;
   logic                     ap_valid;
   logic                     burst;
   logic [2:0]               mux_sel;
   logic [1:0]               tpc;
   logic [1:0]               rcd;
   logic [ADDR_W-1:0]        row_addr;
   logic [ADDR_W-1:0]        col_addr;
   logic                     hit;

   // ----------------------------------------------------------------
   // register fields and bus outputs
   // ----------------------------------------------------------------
   assign burst     = s.control[dram_cfg_pkg::BURST_BIT];
   assign mux_sel   = s.control[dram_cfg_pkg::MUX_MSB:dram_cfg_pkg::MUX_LSB];
   assign tpc       = s.timing[dram_cfg_pkg::TPC_MSB:dram_cfg_pkg::TPC_LSB];
   assign rcd       = s.timing[dram_cfg_pkg::RCD_MSB:dram_cfg_pkg::RCD_LSB];
   assign ap_valid  = hsel && hready && (htrans == dram_cfg_pkg::HTRANS_NONSEQ);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s.rdata;
   assign pins      = s.pins;
   assign req_ack   = (s.fsm == dram_cfg_pkg::SQ_COL);

   // ----------------------------------------------------------------
   // row shift and page compare
   // ----------------------------------------------------------------
   dram_row_cmp #(
      .ADDR_W    (ADDR_W)
   ) u_row_cmp (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .addr      (req.addr),
      .open_addr (s.open_addr),
      .wide      (req.wide),
      .mux_sel   (mux_sel),
      .row_addr  (row_addr),
      .col_addr  (col_addr),
      .hit       (hit)
   );

   // read value of one register, reading the state after any pending write
   function automatic logic [31:0] read_reg(input dram_cfg_pkg::ctl_state_s v,
                                            input logic [7:0] off);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (off)
         dram_cfg_pkg::OFF_CONTROL: r[7:0] = v.control;
         dram_cfg_pkg::OFF_TIMING:  r[7:0] = v.timing;
         dram_cfg_pkg::OFF_STATUS: begin
            r[dram_cfg_pkg::ST_ROW_OPEN] = !v.pins.ras_n;
            r[dram_cfg_pkg::ST_BUSY]     = (v.fsm != dram_cfg_pkg::SQ_IDLE);
            r[dram_cfg_pkg::ST_LAST_HIT] = v.last_hit;
         end
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction : read_reg

   // ----------------------------------------------------------------
   // next state: bus slave and access sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      // data phase of a write lands here
      if (s.dp_wr) begin
         case (s.dp_addr)
            dram_cfg_pkg::OFF_CONTROL: next_s.control = hwdata[7:0] & dram_cfg_pkg::CONTROL_MASK;
            dram_cfg_pkg::OFF_TIMING:  next_s.timing  = hwdata[7:0];
            default: ;
         endcase
      end
      next_s.dp_wr = 1'b0;
      if (ap_valid) begin
         next_s.dp_wr   = hwrite;
         next_s.dp_addr = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
         if (!hwrite) begin
            next_s.rdata = read_reg(next_s, next_s.dp_addr);
         end
      end
      // access sequencer
      case (s.fsm)
         dram_cfg_pkg::SQ_IDLE: begin
            if (req.valid) begin
               next_s.fsm        = dram_cfg_pkg::SQ_ROW;
               next_s.open_addr  = req.addr;
               next_s.last_hit   = 1'b0;
               next_s.pins.addr  = row_addr;
               next_s.pins.ras_n = 1'b0;
            end
         end
         dram_cfg_pkg::SQ_ROW: begin
            if (rcd == dram_cfg_pkg::CNT_ZERO) begin
               next_s.fsm        = dram_cfg_pkg::SQ_COL;
               next_s.pins.addr  = col_addr;
               next_s.pins.cas_n = 1'b0;
            end else begin
               next_s.fsm = dram_cfg_pkg::SQ_RCD;
               next_s.cnt = rcd - dram_cfg_pkg::CNT_ONE;
            end
         end
         dram_cfg_pkg::SQ_RCD: begin
            if (s.cnt == dram_cfg_pkg::CNT_ZERO) begin
               next_s.fsm        = dram_cfg_pkg::SQ_COL;
               next_s.pins.addr  = col_addr;
               next_s.pins.cas_n = 1'b0;
            end else begin
               next_s.cnt = s.cnt - dram_cfg_pkg::CNT_ONE;
            end
         end
         dram_cfg_pkg::SQ_COL: begin
            next_s.fsm        = dram_cfg_pkg::SQ_PAGE;
            next_s.pins.cas_n = 1'b1;
         end
         dram_cfg_pkg::SQ_PAGE: begin
            // fast page: a same-row request goes straight to its column
            if (burst && req.valid && hit) begin
               next_s.fsm        = dram_cfg_pkg::SQ_COL;
               next_s.last_hit   = 1'b1;
               next_s.pins.addr  = col_addr;
               next_s.pins.cas_n = 1'b0;
            end else begin
               next_s.fsm        = dram_cfg_pkg::SQ_PRE;
               next_s.pins.ras_n = 1'b1;
               next_s.cnt        = tpc;
            end
         end
         dram_cfg_pkg::SQ_PRE: begin
            if (s.cnt == dram_cfg_pkg::CNT_ZERO) begin
               next_s.fsm = dram_cfg_pkg::SQ_IDLE;
            end else begin
               next_s.cnt = s.cnt - dram_cfg_pkg::CNT_ONE;
            end
         end
         default: begin
            next_s.fsm        = dram_cfg_pkg::SQ_IDLE;
            next_s.pins.ras_n = 1'b1;
            next_s.pins.cas_n = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s            <= '0;
         s.fsm        <= dram_cfg_pkg::SQ_IDLE;
         s.control    <= dram_cfg_pkg::RST_CONTROL;
         s.timing     <= dram_cfg_pkg::RST_TIMING;
         s.pins.ras_n <= 1'b1;
         s.pins.cas_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // check helpers: lengths of the precharge and RAS-to-CAS spans
   // ----------------------------------------------------------------
   logic [2:0] pre_len;
   logic [2:0] rc_len;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_len <= 3'h0;
         rc_len  <= 3'h0;
      end else begin
         pre_len <= (s.fsm == dram_cfg_pkg::SQ_PRE) ? pre_len + 3'h1 : 3'h0;
         rc_len  <= (s.fsm == dram_cfg_pkg::SQ_ROW || s.fsm == dram_cfg_pkg::SQ_RCD) ?
                    rc_len + 3'h1 : 3'h0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence page_to_col;
      (s.fsm == dram_cfg_pkg::SQ_PAGE) ##1 (s.fsm == dram_cfg_pkg::SQ_COL);
   endsequence
   sequence pre_to_idle;
      (s.fsm == dram_cfg_pkg::SQ_PRE) ##1 (s.fsm == dram_cfg_pkg::SQ_IDLE);
   endsequence
   sequence ras_to_cas;
      (s.fsm == dram_cfg_pkg::SQ_ROW || s.fsm == dram_cfg_pkg::SQ_RCD)
      ##1 (s.fsm == dram_cfg_pkg::SQ_COL);
   endsequence

   chk_row_shift_out: assert property ((s.fsm == dram_cfg_pkg::SQ_IDLE && req.valid
      && mux_sel == 3'h2) |=> (!pins.ras_n && pins.addr == ($past(req.addr) >> 10)))
      else $error("row address not shifted by ten");
   chk_page_hit_only: assert property (page_to_col |-> $past(hit) && $past(burst))
      else $error("page reuse without a row hit");
   chk_prech_len: assert property (pre_to_idle |-> (pre_len == {1'b0, $past(tpc)} + 3'h1))
      else $error("precharge length wrong");
   chk_ras_cas_gap: assert property (ras_to_cas |-> (rc_len == {1'b0, $past(rcd)} + 3'h1))
      else $error("ras to cas gap wrong");
   chk_cas_in_row: assert property ((s.fsm == dram_cfg_pkg::SQ_COL) |->
      (!pins.ras_n && !pins.cas_n ##1 pins.cas_n)) else $error("cas strobe outside open row");
   chk_timing_keep: assert property ((ap_valid && hwrite
      && haddr == {24'h00_0000, dram_cfg_pkg::OFF_TIMING})
      |=> ##1 (s.timing == $past(hwdata[7:0]))) else $error("timing register lost bits");
   chk_full_access: assert property ((s.fsm == dram_cfg_pkg::SQ_PAGE && !burst)
      |=> (s.fsm == dram_cfg_pkg::SQ_PRE && pins.ras_n)) else $error("burst while disabled");

   // ----------------------------------------------------------------
   // checks: strobe levels, address words, bus and page reuse
   // ----------------------------------------------------------------
   // a column cycle entered from any other state
   sequence col_entry;
      (s.fsm != dram_cfg_pkg::SQ_COL) ##1 (s.fsm == dram_cfg_pkg::SQ_COL);
   endsequence
   // a same-row request taken in the page cycle
   sequence page_hit_step;
      (s.fsm == dram_cfg_pkg::SQ_PAGE && burst && req.valid && hit)
      ##1 (s.fsm == dram_cfg_pkg::SQ_COL);
   endsequence

   // both strobes high whenever no row is open
   chk_idle_strobes: assert property ((s.fsm == dram_cfg_pkg::SQ_IDLE)
      |-> (pins.ras_n && pins.cas_n)) else $error("strobes active while idle");
   chk_pre_strobes: assert property ((s.fsm == dram_cfg_pkg::SQ_PRE)
      |-> (pins.ras_n && pins.cas_n)) else $error("strobe low in precharge");
   // row open and CAS still high outside the column cycle
   chk_row_strobes: assert property ((s.fsm == dram_cfg_pkg::SQ_ROW)
      |-> (!pins.ras_n && pins.cas_n)) else $error("strobes wrong in row cycle");
   chk_wait_strobes: assert property ((s.fsm == dram_cfg_pkg::SQ_RCD)
      |-> (!pins.ras_n && pins.cas_n)) else $error("strobes wrong in wait cycle");
   chk_page_strobes: assert property ((s.fsm == dram_cfg_pkg::SQ_PAGE)
      |-> (!pins.ras_n && pins.cas_n)) else $error("strobes wrong in page cycle");

   // row word for each legal select code
   chk_row_shift_c0: assert property ((s.fsm == dram_cfg_pkg::SQ_IDLE && req.valid
      && mux_sel == 3'h0) |=> (pins.addr == ($past(req.addr) >> 8)))
      else $error("row address not shifted by eight");
   chk_row_shift_c1: assert property ((s.fsm == dram_cfg_pkg::SQ_IDLE && req.valid
      && mux_sel == 3'h1) |=> (pins.addr == ($past(req.addr) >> 9)))
      else $error("row address not shifted by nine");
   chk_row_shift_c3: assert property ((s.fsm == dram_cfg_pkg::SQ_IDLE && req.valid
      && mux_sel == 3'h3) |=> (pins.addr == ($past(req.addr) >> 11)))
      else $error("row address not shifted by eleven");

   // column word keeps only the bits below the row shift
   chk_col_low_c0: assert property (col_entry |-> (mux_sel != 3'h0
      || pins.addr == {16'h0, $past(req.addr[7:0])}))
      else $error("column word wrong for code zero");
   chk_col_low_c1: assert property (col_entry |-> (mux_sel != 3'h1
      || pins.addr == {15'h0, $past(req.addr[8:0])}))
      else $error("column word wrong for code one");
   chk_col_low_c3: assert property (col_entry |-> (mux_sel != 3'h3
      || pins.addr == {13'h0, $past(req.addr[10:0])}))
      else $error("column word wrong for code three");

   // a page hit keeps RAS low and strobes CAS again
   chk_page_keeps_row: assert property (page_hit_step
      |-> (!pins.ras_n && !pins.cas_n && s.last_hit))
      else $error("page hit did not reuse the open row");

   // one acknowledge per column cycle
   chk_ack_single: assert property (req_ack |=> !req_ack)
      else $error("acknowledge held two cycles");
   // read data stands until the next read is taken
   chk_rdata_hold: assert property ((!ap_valid || hwrite) |=> $stable(hrdata))
      else $error("read data moved outside a read");
   // control write shows two cycles after its address phase, fields only
   chk_control_lands: assert property ((ap_valid && hwrite
      && haddr == {24'h00_0000, dram_cfg_pkg::OFF_CONTROL})
      |=> ##1 (s.control == ($past(hwdata[7:0]) & dram_cfg_pkg::CONTROL_MASK)))
      else $error("control write lost");
endmodule : dram_addr_mux_timing_cfg
`default_nettype wire

// file: dram_cfg_pkg.sv
`default_nettype none
package dram_cfg_pkg;
   // ----------------------------------------------------------------
   // widths and register map
   // ----------------------------------------------------------------
   localparam int         ADDR_W         = 24;
   localparam logic [7:0] OFF_CONTROL    = 8'h00;   // burst enable, mux select
   localparam logic [7:0] OFF_TIMING     = 8'h04;   // dram_access_timing
   localparam logic [7:0] OFF_STATUS     = 8'h08;   // read-only sequencer state
   localparam logic [7:0] RST_CONTROL    = 8'h00;
   localparam logic [7:0] RST_TIMING     = 8'h00;
   localparam logic [7:0] CONTROL_MASK   = 8'h87;   // writable control bits

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int         BURST_BIT      = 7;
   localparam int         MUX_LSB        = 0;
   localparam int         MUX_MSB        = 2;
   localparam int         TPC_LSB        = 4;
   localparam int         TPC_MSB        = 5;
   localparam int         RCD_LSB        = 0;
   localparam int         RCD_MSB        = 1;
   localparam int         ST_ROW_OPEN    = 0;
   localparam int         ST_BUSY        = 1;
   localparam int         ST_LAST_HIT    = 2;

   // ----------------------------------------------------------------
   // address multiplexing and bus codes
   // ----------------------------------------------------------------
   localparam logic [3:0] MUX_BASE_SHIFT = 4'h8;    // shift for code 000
   localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0] CNT_ZERO       = 2'h0;
   localparam logic [1:0] CNT_ONE        = 2'h1;

   typedef enum logic [2:0] {
      SQ_IDLE = 3'h0,
      SQ_ROW  = 3'h1,
      SQ_RCD  = 3'h3,
      SQ_COL  = 3'h2,
      SQ_PAGE = 3'h6,
      SQ_PRE  = 3'h4
   } seq_e;

   typedef struct packed {
      logic              valid;   // access request held until acknowledged
      logic [ADDR_W-1:0] addr;    // byte address A23..A0
      logic              wide;    // 1: 16-bit access space
   } dram_req_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;    // multiplexed address bus
      logic              ras_n;
      logic              cas_n;
   } dram_pins_s;

   typedef struct packed {
      seq_e              fsm;
      logic [1:0]        cnt;
      logic [ADDR_W-1:0] open_addr;
      logic [7:0]        control;
      logic [7:0]        timing;
      logic              dp_wr;
      logic [7:0]        dp_addr;
      logic [31:0]       rdata;
      dram_pins_s        pins;
      logic              last_hit;
   } ctl_state_s;
endpackage : dram_cfg_pkg
`default_nettype wire

// file: dram_row_cmp.sv
`default_nettype none
module dram_row_cmp #(
   parameter int ADDR_W = 24
) (
   input  wire logic              hclk,       // clock for checks only
   input  wire logic              hresetn,    // reset for checks only
   input  wire logic [ADDR_W-1:0] addr,       // new access address
   input  wire logic [ADDR_W-1:0] open_addr,  // address that opened the row
   input  wire logic              wide,       // 16-bit access space
   input  wire logic [2:0]        mux_sel,    // address_mux_select
   output logic      [ADDR_W-1:0] row_addr,   // address shifted for the row phase
   output logic      [ADDR_W-1:0] col_addr,   // address kept for the column phase
   output logic                   hit         // same row as the open one
);
   logic [3:0]        shift;
   logic [3:0]        cmp_low;
   logic [ADDR_W-1:0] mask;

   // ----------------------------------------------------------------
   // shift and compare window
   // ----------------------------------------------------------------
   always_comb begin
      shift    = dram_cfg_pkg::MUX_BASE_SHIFT + {2'h0, mux_sel[1:0]};
      cmp_low  = shift + {3'h0, wide};
      mask     = {ADDR_W{1'b1}} << cmp_low;
      row_addr = addr >> shift;
      col_addr = addr & ~({ADDR_W{1'b1}} << shift);
      // codes with the top bit set never report a hit
      hit      = !mux_sel[2] && (((addr ^ open_addr) & mask) == '0);
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_cmp_narrow_lo: assert property ((!wide && mux_sel == 3'h0) |->
      (hit == (addr[23:8] == open_addr[23:8]))) else $error("narrow compare code 0 wrong");
   chk_cmp_narrow_hi: assert property ((!wide && mux_sel == 3'h3) |->
      (hit == (addr[23:11] == open_addr[23:11]))) else $error("narrow compare code 3 wrong");
   chk_cmp_wide_lo: assert property ((wide && mux_sel == 3'h0) |->
      (hit == (addr[23:9] == open_addr[23:9]))) else $error("wide compare code 0 wrong");
   chk_cmp_wide_hi: assert property ((wide && mux_sel == 3'h3) |->
      (hit == (addr[23:12] == open_addr[23:12]))) else $error("wide compare code 3 wrong");
endmodule : dram_row_cmp
`default_nettype wire

// file: dram_model.sv
`default_nettype none
module dram_model (
   input  wire logic                     hclk,        // system clock
   input  wire logic                     clr,         // clears the records
   input  wire dram_cfg_pkg::dram_pins_s pins,        // address and strobes from the block
   output var  logic [23:0]              row_q,       // row latched at RAS fall
   output var  logic [23:0]              col_q,       // column latched at CAS fall
   output var  int                       ras_falls,   // count of row activations
   output var  int                       ras_to_cas,  // cycles from RAS fall to CAS fall
   output var  int                       pre_len      // cycles RAS stays high between rows
);
   timeunit 1ns;
   timeprecision 1ns;
   logic ras_d = 1'b1;
   logic cas_d = 1'b1;
   int   cyc    = 0;
   int   t_ras  = 0;
   int   t_rise = 0;
   bit   rised  = 1'b0;
   bit   armed  = 1'b0;
   // ----------------------------------------------------------------
   // strobe edge watcher, sees pin values of the cycle just ended
   // ----------------------------------------------------------------
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (clr) begin
         ras_falls  = 0;
         ras_to_cas = 0;
         pre_len    = 0;
         rised      = 1'b0;
      end else begin
         if (ras_d && !pins.ras_n) begin
            ras_falls = ras_falls + 1;
            row_q     = pins.addr;
            t_ras     = cyc;
            armed     = 1'b1;
            if (rised) pre_len = cyc - t_rise;
         end
         if (!ras_d && pins.ras_n) begin
            t_rise = cyc;
            rised  = 1'b1;
         end
         if (cas_d && !pins.cas_n) begin
            col_q      = pins.addr;
            // only the first column after a row fall gives the RAS-to-CAS gap
            if (armed) ras_to_cas = cyc - t_ras;
            armed      = 1'b0;
         end
      end
      ras_d = pins.ras_n;
      cas_d = pins.cas_n;
   end
endmodule : dram_model
`default_nettype wire

// file: test_dram_addr_mux_timing_cfg.sv
`default_nettype none
module test_dram_addr_mux_timing_cfg;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [23:0] A1 = 24'h123456;
   typedef struct packed {
      logic [7:0]  ctrl;   // burst enable and mux select
      logic [7:0]  tim;    // precharge and ras-to-cas codes
      logic        wide;   // 16-bit access space
      logic [23:0] a2;     // address of the following access
      logic        hit;    // page hit expected
   } row_s;
   row_s rows [12] = '{
      '{8'h80, 8'h00, 1'b0, 24'h1234FF, 1'b1}, '{8'h80, 8'h11, 1'b0, 24'h123556, 1'b0},
      '{8'h80, 8'h22, 1'b1, 24'h123556, 1'b1}, '{8'h81, 8'h33, 1'b0, 24'h123556, 1'b1},
      '{8'h81, 8'h01, 1'b1, 24'h123656, 1'b1}, '{8'h82, 8'h02, 1'b0, 24'h123056, 1'b0},
      '{8'h82, 8'h13, 1'b1, 24'h123056, 1'b1}, '{8'h83, 8'h20, 1'b0, 24'h123C56, 1'b0},
      '{8'h83, 8'h31, 1'b1, 24'h123C56, 1'b1}, '{8'h83, 8'h30, 1'b1, 24'h122456, 1'b0},
      '{8'h00, 8'h10, 1'b0, 24'h123456, 1'b0}, '{8'h03, 8'h23, 1'b0, 24'h123456, 1'b0}};
   logic                     hclk    = 1'b0;
   logic                     hresetn = 1'b0;
   logic                     hsel    = 1'b0;
   logic [31:0]              haddr   = 32'h0;
   logic [1:0]               htrans  = 2'h0;
   logic                     hwrite  = 1'b0;
   logic [2:0]               hsize   = 3'h2;
   logic [31:0]              hwdata  = 32'h0;
   logic                     clr     = 1'b0;
   dram_cfg_pkg::dram_req_s  req     = '0;
   wire logic                hready;
   logic                     hreadyout;
   logic                     hresp;
   logic [31:0]              hrdata;
   logic                     req_ack;
   dram_cfg_pkg::dram_pins_s pins;
   logic [23:0]              row_q;
   logic [23:0]              col_q;
   int                       ras_falls;
   int                       ras_to_cas;
   int                       pre_len;
   int                       error_cnt = 0;
   int                       n_tests   = 0;
   int                       cyc       = 0;
   logic [31:0]              rd;
   int                       sh;
   assign hready = hreadyout;
   always #10 hclk = ~hclk;
   dram_addr_mux_timing_cfg dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req(req), .req_ack(req_ack),
      .pins(pins));
   dram_model mem (.hclk(hclk), .clr(clr), .pins(pins), .row_q(row_q), .col_q(col_q),
      .ras_falls(ras_falls), .ras_to_cas(ras_to_cas), .pre_len(pre_len));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task conclude;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   // one single word transfer, address phase then data phase
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= dram_cfg_pkg::HTRANS_NONSEQ;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask : ahb
   task wait_ack;
      do @(negedge hclk); while (req_ack !== 1'b1);
   endtask : wait_ack
   // cuts a hang short
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         error_cnt = error_cnt + 1;
         conclude();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      check("ras_n idle", {31'h0, pins.ras_n}, 32'h1);
      check("cas_n idle", {31'h0, pins.cas_n}, 32'h1);
      ahb(1'b0, dram_cfg_pkg::OFF_CONTROL, 32'h0);
      check("control reset", rd, 32'h0);
      ahb(1'b0, dram_cfg_pkg::OFF_TIMING, 32'h0);
      check("timing reset", rd, {24'h0, dram_cfg_pkg::RST_TIMING});
      ahb(1'b0, dram_cfg_pkg::OFF_STATUS, 32'h0);
      check("status reset", rd, 32'h0);
      for (int i = 0; i < 12; i++) begin
         ahb(1'b1, dram_cfg_pkg::OFF_CONTROL, {24'h0, rows[i].ctrl});
         ahb(1'b1, dram_cfg_pkg::OFF_TIMING, {24'h0, rows[i].tim});
         sh = 8 + int'(rows[i].ctrl[1:0]);
         @(posedge hclk);
         clr <= 1'b1;
         req <= '{1'b1, A1, rows[i].wide};
         @(posedge hclk);
         clr <= 1'b0;
         wait_ack();
         @(posedge hclk);
         req.addr <= rows[i].a2;
         wait_ack();
         @(posedge hclk);
         req.valid <= 1'b0;
         repeat (10) @(posedge hclk);
         check("ras count", ras_falls, rows[i].hit ? 1 : 2);
         check("row", {8'h0, row_q}, {8'h0, (rows[i].hit ? A1 : rows[i].a2) >> sh});
         check("col", {8'h0, col_q}, {8'h0, rows[i].a2 & ((24'h1 << sh) - 24'h1)});
         check("rcd", ras_to_cas, int'(rows[i].tim[1:0]) + 1);
         if (!rows[i].hit) check("pre", pre_len, int'(rows[i].tim[5:4]) + 2);
         ahb(1'b0, dram_cfg_pkg::OFF_STATUS, 32'h0);
         check("last hit", {31'h0, rd[dram_cfg_pkg::ST_LAST_HIT]}, {31'h0, rows[i].hit});
      end
      // reserved timing bits keep what is written, control keeps only its fields
      ahb(1'b1, dram_cfg_pkg::OFF_TIMING, 32'h000000CC);
      ahb(1'b0, dram_cfg_pkg::OFF_TIMING, 32'h0);
      check("timing reserved", rd, 32'h000000CC);
      ahb(1'b1, dram_cfg_pkg::OFF_CONTROL, 32'h000000FB);
      ahb(1'b0, dram_cfg_pkg::OFF_CONTROL, 32'h0);
      check("control mask", rd, {24'h0, 8'hFB & dram_cfg_pkg::CONTROL_MASK});
      ahb(1'b1, 8'h0C, 32'h0000005A);
      ahb(1'b0, 8'h0C, 32'h0);
      check("unmapped", rd, 32'h0);
      // reset in mid-run: the open row closes and the registers return to reset
      req <= '{1'b1, A1, 1'b0};
      repeat (2) @(posedge hclk);
      hresetn   <= 1'b0;
      req.valid <= 1'b0;
      @(negedge hclk);
      check("ras_n in reset", {31'h0, pins.ras_n}, 32'h1);
      check("cas_n in reset", {31'h0, pins.cas_n}, 32'h1);
      @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, dram_cfg_pkg::OFF_TIMING, 32'h0);
      check("timing after reset", rd, {24'h0, dram_cfg_pkg::RST_TIMING});
      ahb(1'b0, dram_cfg_pkg::OFF_CONTROL, 32'h0);
      check("control after reset", rd, {24'h0, dram_cfg_pkg::RST_CONTROL});
      conclude();
   end
endmodule : test_dram_addr_mux_timing_cfg
`default_nettype wire
